// ---- rtl/ssi_pkg.sv ----
// Constants, types and register map of the serial shifter block.
// Assumes a processor bus on the same clock as the block.
`default_nettype none

package ssi_pkg;

   // ==================================================================
   // Register offsets on the four-bit register select.
   localparam logic [3:0] OFS_T2_LATCH_LO = 4'h8;
   localparam logic [3:0] OFS_SHIFTER = 4'hA;
   localparam logic [3:0] OFS_AUX_CTRL = 4'hB;
   localparam logic [3:0] OFS_PERIPH_CTRL = 4'hC;
   localparam logic [3:0] OFS_IFR = 4'hD;
   localparam logic [3:0] OFS_IER = 4'hE;

   // ==================================================================
   // Shift modes held in the auxiliary control register.
   localparam int ACR_MODE_LSB = 2;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_IN_T2 = 3'h1;
   localparam logic [2:0] MODE_IN_SYS = 3'h2;
   localparam logic [2:0] MODE_IN_EXT = 3'h3;
   localparam logic [2:0] MODE_OUT_FREE = 3'h4;
   localparam logic [2:0] MODE_OUT_T2 = 3'h5;
   localparam logic [2:0] MODE_OUT_SYS = 3'h6;
   localparam logic [2:0] MODE_OUT_EXT = 3'h7;
   localparam int MODE_OUT_BIT = 2;

   // ==================================================================
   // Field positions.
   localparam int FLAG_SHIFT = 2;
   localparam int IRQ_BIT = 7;
   localparam int IER_SET_BIT = 7;
   localparam int PCR_CLK_OE = 0;
   localparam int PCR_CLK_LVL = 1;
   localparam int PCR_DAT_OE = 2;
   localparam int PCR_DAT_LVL = 3;

   // ==================================================================
   // Counts and reset values.
   localparam logic [3:0] SHIFT_BITS = 4'h8;
   localparam logic [8:0] T2_OVERHEAD = 9'h002;
   localparam logic [8:0] SYS_HALF = 9'h001;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ==================================================================
   // Types.
   typedef enum logic {ST_IDLE, ST_RUN} ssi_state_t;

   typedef struct packed {
      logic sel;
      logic rd;
      logic [3:0] rs;
      logic [7:0] wdata;
   } ssi_bus_req_t;

   typedef struct packed {
      logic o;
      logic oe_n;
   } ssi_pin_t;

endpackage

`default_nettype wire

// ---- rtl/ssi_sync.sv ----
// Two flip-flop synchroniser for single-bit levels.
// Assumes the input is a level from another domain or a pin.
`default_nettype none

module ssi_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);

   // ==================================================================
   // Synchroniser stages.
   logic meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/ssi_tick.sv ----
// Half-period tick generator for the internally made shift clock.
// Assumes half is stable while run is high and is at least one.
`default_nettype none

module ssi_tick #(
   parameter int W = 9
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [W-1:0] half,
   output logic tick
);

   // ==================================================================
   // Down counter reloaded with half minus one.
   typedef struct packed {
      logic [W-1:0] cnt;
   } ssi_tick_st_t;

   ssi_tick_st_t st_q;
   ssi_tick_st_t st_d;

   assign tick = run && (st_q.cnt == '0);

   always_comb begin
      st_d = st_q;
      if (!run || tick) begin
         st_d.cnt = W'(half - W'(1));
      end else begin
         st_d.cnt = W'(st_q.cnt - W'(1));
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/ssi_top.sv ----
// Serial shifter with interrupt flag and enable logic.
// Assumes a processor bus on clk and an external shift clock on its own
// clock port; the shift data pin is asynchronous to clk.
//
// Summary of operation
// - Shift data through the data pin, tracked by a bit counter that stops at eight in counted modes and is modulo-8 in external modes.
// - Mode off: shifter still accessible, pins per control, flag held zero.
// - Timer-rate shift-in drives clock edges spaced by timer low latch plus two.
// - In counted modes any shifter read or write starts a new shift.
// - Shift-in enters bit 0, sampled the cycle after clock rising edge.
// - Timer-rate shift-in sets the done flag after eight pulses.
// - System-rate shift-in pulses clock, stops it after eight, sets flag.
// - External-clock shift-in never stops; flag each eight; access restarts.
// - Free-running shift-out recirculates top bit; no count, no flag.
// - Counted timer-rate shift-out sends eight bits, stops, holds last bit.
// - System-rate shift-out derives its rate straight from the clock.
// - External-clock shift-out flags every eight pulses; access restarts.
// - Interrupt output is open-drain, active low, any flag with enable.
// - Flag register bit 7 reads the OR of flags ANDed with enables.
// - Writing one to a flag bit clears it; zeros leave it.
// - Bit 7 of flag register ignores writes; follows flags and enables.
// - Enable write with bit 7 low clears enables where data is one.
// - Enable write with bit 7 high sets enables where data is one.
// - Enable register reads one in bit 7 and the enables below.
`default_nettype none

module ssi_top (
   input wire logic clk,
   input wire logic rst,
   input wire ssi_pkg::ssi_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   input wire logic [6:0] irq_sources,
   input wire logic shift_clock_pin_i,
   output var ssi_pkg::ssi_pin_t shift_clock_pin,
   input wire logic shift_data_pin_i,
   output var ssi_pkg::ssi_pin_t shift_data_pin,
   output var ssi_pkg::ssi_pin_t irq_n
);

   // ==================================================================
   // State of the system-clock side.
   typedef struct packed {
      ssi_pkg::ssi_state_t state;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic sclk;
      logic pend;
      logic dout;
      logic prev;
      logic [6:0] flags;
      logic [6:0] en;
      logic [7:0] aux_control_reg;
      logic [7:0] periph_control_reg;
      logic [7:0] t2l;
      logic [7:0] rdata;
      logic irq_act;
      ssi_pkg::ssi_pin_t cpin;
      ssi_pkg::ssi_pin_t dpin;
   } ssi_st_t;

   localparam ssi_st_t ST_RST = '{
      state: ssi_pkg::ST_IDLE,
      sclk: 1'b1,
      cpin: '{o: 1'b1, oe_n: 1'b1},
      dpin: '{o: 1'b1, oe_n: 1'b1},
      default: '0
   };

   // ==================================================================
   // State of the link side, clocked by the external shift clock.
   typedef struct packed {
      logic [1:0] cap;
      logic ptr;
   } ssi_link_st_t;

   ssi_st_t st_q;
   ssi_st_t st_d;
   ssi_link_st_t lk_q;
   logic link_rst;
   logic ptr_s;
   logic din_s;
   logic tick;
   logic [2:0] mode;
   logic [2:0] mode_n;
   logic is_out;
   logic is_ext;
   logic counted;
   logic acc;
   logic wr;
   logic ev;
   logic set_shift;
   logic [8:0] half;
   logic [6:0] clr;
   logic [6:0] set;

   assign mode = st_q.aux_control_reg[ssi_pkg::ACR_MODE_LSB +: 3];
   assign is_out = mode[ssi_pkg::MODE_OUT_BIT];
   assign is_ext = (mode == ssi_pkg::MODE_IN_EXT) ||
                   (mode == ssi_pkg::MODE_OUT_EXT);
   assign counted = (mode == ssi_pkg::MODE_IN_T2) ||
                    (mode == ssi_pkg::MODE_IN_SYS) ||
                    (mode == ssi_pkg::MODE_OUT_T2) ||
                    (mode == ssi_pkg::MODE_OUT_SYS);
   assign acc = bus_req.sel && (bus_req.rs == ssi_pkg::OFS_SHIFTER);
   assign wr = bus_req.sel && !bus_req.rd;
   assign ev = (ptr_s != st_q.prev);

   // Timer modes use the low latch plus overhead, system modes one cycle.
   always_comb begin
      if ((mode == ssi_pkg::MODE_IN_SYS) ||
          (mode == ssi_pkg::MODE_OUT_SYS)) begin
         half = ssi_pkg::SYS_HALF;
      end else begin
         half = 9'({1'b0, st_q.t2l} + ssi_pkg::T2_OVERHEAD);
      end
   end

   // ==================================================================
   // Crossings and the half-period generator.
   ssi_sync u_link_rst (
      .clk(shift_clock_pin_i),
      .rst(1'b0),
      .d(rst),
      .q(link_rst)
   );

   ssi_sync u_ptr_sync (
      .clk(clk),
      .rst(rst),
      .d(lk_q.ptr),
      .q(ptr_s)
   );

   ssi_sync u_din_sync (
      .clk(clk),
      .rst(rst),
      .d(shift_data_pin_i),
      .q(din_s)
   );

   ssi_tick #(
      .W(9)
   ) u_tick (
      .clk(clk),
      .rst(rst),
      .run((st_q.state == ssi_pkg::ST_RUN) && !is_ext),
      .half(half),
      .tick(tick)
   );

   // ==================================================================
   // Link side: the data pin is caught on each rising shift clock edge
   // into alternating slots, so a bit stays put for two link periods
   // while the system side picks it up behind the pointer crossing.
   always_ff @(posedge shift_clock_pin_i) begin
      if (link_rst) begin
         lk_q <= '0;
      end else begin
         lk_q.cap[lk_q.ptr] <= shift_data_pin_i;
         lk_q.ptr <= !lk_q.ptr;
      end
   end

   // ==================================================================
   // System side next-state logic.
   always_comb begin
      st_d = st_q;
      set_shift = 1'b0;
      st_d.prev = ptr_s;
      if (mode == ssi_pkg::MODE_OFF) begin
         st_d.state = ssi_pkg::ST_IDLE;
         st_d.cnt = '0;
         st_d.sclk = 1'b1;
         st_d.pend = 1'b0;
      end else if (is_ext) begin
         st_d.state = ssi_pkg::ST_RUN;
         if (ev) begin
            if (is_out) begin
               st_d.dout = st_q.sh[7];
               st_d.sh = {st_q.sh[6:0], st_q.sh[7]};
            end else begin
               st_d.sh = {st_q.sh[6:0], lk_q.cap[st_q.prev]};
            end
            if (st_q.cnt == 4'(ssi_pkg::SHIFT_BITS - 4'h1)) begin
               st_d.cnt = '0;
               set_shift = 1'b1;
            end else begin
               st_d.cnt = 4'(st_q.cnt + 4'h1);
            end
         end
         if (acc) begin
            st_d.cnt = '0;
         end
      end else if (acc) begin
         st_d.state = ssi_pkg::ST_RUN;
         st_d.cnt = '0;
         st_d.sclk = 1'b1;
         st_d.pend = 1'b0;
      end else if (st_q.state == ssi_pkg::ST_RUN) begin
         if (tick && !st_q.sclk) begin
            st_d.sclk = 1'b1;
            st_d.pend = 1'b1;
            if (mode != ssi_pkg::MODE_OUT_FREE) begin
               st_d.cnt = 4'(st_q.cnt + 4'h1);
            end
         end else if (tick && !(counted &&
                      (st_q.cnt == ssi_pkg::SHIFT_BITS))) begin
            st_d.sclk = 1'b0;
            if (is_out) begin
               st_d.dout = st_q.sh[7];
               st_d.sh = {st_q.sh[6:0], st_q.sh[7]};
            end
         end
         if (st_q.pend) begin
            st_d.pend = 1'b0;
            if (!is_out) begin
               st_d.sh = {st_q.sh[6:0], din_s};
            end
            if (counted && (st_q.cnt == ssi_pkg::SHIFT_BITS)) begin
               st_d.state = ssi_pkg::ST_IDLE;
               set_shift = 1'b1;
            end
         end
      end

      // Register writes; a shifter write wins over a shift in flight.
      if (wr) begin
         if (bus_req.rs == ssi_pkg::OFS_T2_LATCH_LO) begin
            st_d.t2l = bus_req.wdata;
         end else if (bus_req.rs == ssi_pkg::OFS_SHIFTER) begin
            st_d.sh = bus_req.wdata;
         end else if (bus_req.rs == ssi_pkg::OFS_AUX_CTRL) begin
            st_d.aux_control_reg = bus_req.wdata;
         end else if (bus_req.rs == ssi_pkg::OFS_PERIPH_CTRL) begin
            st_d.periph_control_reg = bus_req.wdata;
         end else if (bus_req.rs == ssi_pkg::OFS_IER) begin
            if (bus_req.wdata[ssi_pkg::IER_SET_BIT]) begin
               st_d.en = st_q.en | bus_req.wdata[6:0];
            end else begin
               st_d.en = st_q.en & ~bus_req.wdata[6:0];
            end
         end
      end

      // Flags: a set in the same cycle as a clear wins.
      clr = '0;
      if (wr && (bus_req.rs == ssi_pkg::OFS_IFR)) begin
         clr = bus_req.wdata[6:0];
      end
      if (acc) begin
         clr[ssi_pkg::FLAG_SHIFT] = 1'b1;
      end
      set = irq_sources;
      set[ssi_pkg::FLAG_SHIFT] = set_shift && (mode != ssi_pkg::MODE_OUT_FREE);
      st_d.flags = (st_q.flags & ~clr) | set;
      mode_n = st_d.aux_control_reg[ssi_pkg::ACR_MODE_LSB +: 3];
      if (mode_n == ssi_pkg::MODE_OFF) begin
         st_d.flags[ssi_pkg::FLAG_SHIFT] = 1'b0;
      end
      st_d.irq_act = |(st_d.flags & st_d.en);

      // Read data.
      if (bus_req.sel && bus_req.rd) begin
         if (bus_req.rs == ssi_pkg::OFS_T2_LATCH_LO) begin
            st_d.rdata = st_q.t2l;
         end else if (bus_req.rs == ssi_pkg::OFS_SHIFTER) begin
            st_d.rdata = st_q.sh;
         end else if (bus_req.rs == ssi_pkg::OFS_AUX_CTRL) begin
            st_d.rdata = st_q.aux_control_reg;
         end else if (bus_req.rs == ssi_pkg::OFS_PERIPH_CTRL) begin
            st_d.rdata = st_q.periph_control_reg;
         end else if (bus_req.rs == ssi_pkg::OFS_IFR) begin
            st_d.rdata = {|(st_q.flags & st_q.en), st_q.flags};
         end else if (bus_req.rs == ssi_pkg::OFS_IER) begin
            st_d.rdata = {1'b1, st_q.en};
         end else begin
            st_d.rdata = ssi_pkg::REG_RESET;
         end
      end

      // Pins: low output enable means driven.
      if (mode_n == ssi_pkg::MODE_OFF) begin
         st_d.cpin.o = st_d.periph_control_reg[ssi_pkg::PCR_CLK_LVL];
         st_d.cpin.oe_n = !st_d.periph_control_reg[ssi_pkg::PCR_CLK_OE];
         st_d.dpin.o = st_d.periph_control_reg[ssi_pkg::PCR_DAT_LVL];
         st_d.dpin.oe_n = !st_d.periph_control_reg[ssi_pkg::PCR_DAT_OE];
      end else begin
         st_d.cpin.o = st_d.sclk;
         st_d.cpin.oe_n = (mode_n == ssi_pkg::MODE_IN_EXT) ||
                          (mode_n == ssi_pkg::MODE_OUT_EXT);
         st_d.dpin.o = st_d.dout;
         st_d.dpin.oe_n = !mode_n[ssi_pkg::MODE_OUT_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus_rdata = st_q.rdata;
   assign shift_clock_pin = st_q.cpin;
   assign shift_data_pin = st_q.dpin;
   assign irq_n = '{o: 1'b0, oe_n: !st_q.irq_act};

   // ==================================================================
   // Assertions.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_irq_out;
      irq_n.oe_n == !(|(st_q.flags & st_q.en));
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("Interrupt pin does not follow flags and enables.");

   property p_ifr_top;
      bus_req.sel && bus_req.rd && (bus_req.rs == ssi_pkg::OFS_IFR) |=>
         bus_rdata[ssi_pkg::IRQ_BIT] == $past(|(st_q.flags & st_q.en));
   endproperty
   a_ifr_top: assert property (p_ifr_top)
      else $error("Flag register top bit is wrong.");

   property p_ier_read;
      bus_req.sel && bus_req.rd && (bus_req.rs == ssi_pkg::OFS_IER) |=>
         bus_rdata == {1'b1, $past(st_q.en)};
   endproperty
   a_ier_read: assert property (p_ier_read)
      else $error("Enable register read is wrong.");

   property p_ier_set;
      wr && (bus_req.rs == ssi_pkg::OFS_IER) && bus_req.wdata[7] |=>
         st_q.en == ($past(st_q.en) | $past(bus_req.wdata[6:0]));
   endproperty
   a_ier_set: assert property (p_ier_set)
      else $error("Enable set write failed.");

   property p_ier_clr;
      wr && (bus_req.rs == ssi_pkg::OFS_IER) && !bus_req.wdata[7] |=>
         st_q.en == ($past(st_q.en) & ~$past(bus_req.wdata[6:0]));
   endproperty
   a_ier_clr: assert property (p_ier_clr)
      else $error("Enable clear write failed.");

   property p_ifr_clr;
      wr && (bus_req.rs == ssi_pkg::OFS_IFR) && bus_req.wdata[0] &&
         !irq_sources[0] |=> !st_q.flags[0];
   endproperty
   a_ifr_clr: assert property (p_ifr_clr)
      else $error("Flag not cleared by a one write.");

   property p_off_flag;
      (mode == ssi_pkg::MODE_OFF) |-> !st_q.flags[ssi_pkg::FLAG_SHIFT];
   endproperty
   a_off_flag: assert property (p_off_flag)
      else $error("Shift flag set while shifter is off.");

   property p_free_noflag;
      (mode == ssi_pkg::MODE_OUT_FREE) && !acc && (st_q.aux_control_reg == $past(st_q.aux_control_reg))
         |=> !$rose(st_q.flags[ssi_pkg::FLAG_SHIFT]);
   endproperty
   a_free_noflag: assert property (p_free_noflag)
      else $error("Free-running mode raised the shift flag.");

   property p_start;
      acc && counted && !wr |=>
         (st_q.state == ssi_pkg::ST_RUN) && (st_q.cnt == 4'h0) ##1
         (st_q.state == ssi_pkg::ST_RUN);
   endproperty
   a_start: assert property (p_start)
      else $error("Shifter access did not start a shift.");

   property p_sample;
      st_q.pend && !is_out && !is_ext && (mode != ssi_pkg::MODE_OFF) && !acc
         |=> st_q.sh[0] == $past(din_s);
   endproperty
   a_sample: assert property (p_sample)
      else $error("Shift-in sample not taken into bit zero.");

endmodule

`default_nettype wire

// ---- sim/ssi_peer.sv ----
// Behavioural model of the serial peer on the shift clock and data pins.
// Assumes the bench resolves both pin lines and pulses go once per frame.
`default_nettype none

module ssi_peer (
   input wire logic clk_line,
   input wire logic dat_line,
   input wire logic go,
   input wire logic [3:0] npls,
   input wire logic [7:0] tx,
   output logic ext_clk,
   output logic dat_o,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Frame clock, sent bits and captured bits.
   int k;
   initial begin
      ext_clk = 1'b1;
      dat_o = 1'b0;
      rx = 8'h00;
      k = 8;
   end
   always @(posedge go) begin
      k = 0;
      repeat (npls) begin
         #32 ext_clk = 1'b0;
         #32 ext_clk = 1'b1;
      end
   end
   always @(negedge clk_line) begin
      if (k < 8) dat_o = tx[7-k];
      else dat_o = ~dat_o;
      k = k + 1;
   end
   always @(posedge clk_line) rx = {rx[6:0], dat_line};
endmodule

`default_nettype wire

// ---- sim/test_ssi_top.sv ----
// Self-checking bench for the serial shifter with its flag logic.
// Assumes ssi_pkg, ssi_top and ssi_peer are compiled before it.
`default_nettype none

module test_ssi_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Clock, pins, design and peer.
   localparam logic [3:0] A_SH = ssi_pkg::OFS_SHIFTER;
   localparam logic [3:0] A_IFR = ssi_pkg::OFS_IFR;
   localparam logic [3:0] A_IER = ssi_pkg::OFS_IER;
   logic clk = 1'b0;
   logic rst = 1'b1;
   ssi_pkg::ssi_bus_req_t bus_req = '0;
   logic [7:0] rdata;
   logic [6:0] src = 7'h00;
   ssi_pkg::ssi_pin_t ckp, dtp, irq;
   logic go = 1'b0;
   logic [3:0] npls = 4'h0;
   logic [7:0] tx = 8'h00;
   logic ext_clk, dat_o;
   logic [7:0] rx;
   int fails = 0;
   int n_compared = 0;
   int np = 0;
   time tf, tl;
   wire logic clk_line = ckp.oe_n ? ext_clk : ckp.o;
   wire logic dat_line = dtp.oe_n ? dat_o : dtp.o;

   always #10 clk = ~clk;
   always @(negedge clk_line) begin
      np++;
      tl = $time;
      if (np == 1) tf = $time;
   end

   ssi_top dut_u (.clk(clk), .rst(rst), .bus_req(bus_req),
      .bus_rdata(rdata), .irq_sources(src), .shift_clock_pin_i(clk_line),
      .shift_clock_pin(ckp), .shift_data_pin_i(dat_line),
      .shift_data_pin(dtp), .irq_n(irq));
   ssi_peer peer_u (.clk_line(clk_line), .dat_line(dat_line), .go(go),
      .npls(npls), .tx(tx), .ext_clk(ext_clk), .dat_o(dat_o), .rx(rx));

   // ==========
   // Shared tasks.
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic acc(input logic r, input logic [3:0] rs,
                      input logic [7:0] d);
      @(negedge clk);
      bus_req = '{sel: 1'b1, rd: r, rs: rs, wdata: d};
      @(negedge clk);
      bus_req.sel = 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [3:0] rs,
                       input logic [7:0] e);
      acc(1'b1, rs, 8'h00);
      @(negedge clk);
      chk(nm, e, rdata);
   endtask
   task automatic set_mode(input logic [2:0] m);
      acc(1'b0, ssi_pkg::OFS_AUX_CTRL, {3'h0, m, 2'h0});
   endtask
   task automatic frame(input logic [3:0] n);
      npls = n;
      np = 0;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
   endtask
   task automatic wait_irq;
      int i;
      i = 0;
      while (irq.oe_n !== 1'b0 && i < 1000) begin
         @(negedge clk);
         i++;
      end
      chk("irq_wait", 8'h00, {7'h00, irq.oe_n});
   endtask

   // ==========
   // Scenarios.
   task automatic t_regs;
      rchk("ier_rst", A_IER, 8'h80);
      acc(1'b0, A_IER, 8'h95);
      acc(1'b0, A_IER, 8'h11);
      rchk("ier", A_IER, 8'h84);
      src = 7'h11;
      @(negedge clk);
      src = 7'h00;
      rchk("ifr_masked", A_IFR, 8'h11);
      chk("irq_off", 8'h01, {7'h00, irq.oe_n});
      acc(1'b0, A_IER, 8'h90);
      repeat (2) @(negedge clk);
      chk("irq_on", 8'h00, {6'h00, irq.oe_n, irq.o});
      acc(1'b0, A_IFR, 8'h80);
      rchk("ifr_b7", A_IFR, 8'h91);
      acc(1'b0, A_IFR, 8'h10);
      rchk("ifr_clr", A_IFR, 8'h01);
      acc(1'b0, A_IFR, 8'h01);
      acc(1'b0, A_IER, 8'h10);
      rchk("unmapped", 4'hF, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_off;
      set_mode(ssi_pkg::MODE_OFF);
      acc(1'b0, ssi_pkg::OFS_PERIPH_CTRL, 8'h07);
      frame(4'h0);
      acc(1'b0, A_SH, 8'h5A);
      repeat (4) @(negedge clk);
      chk("pins", 8'h04, {4'h0, ckp.oe_n, ckp.o, dtp.oe_n, dtp.o});
      rchk("sh_off", A_SH, 8'h5A);
      rchk("flag_off", A_IFR, 8'h00);
      chk("np_off", 8'h00, 8'(np));
      acc(1'b0, ssi_pkg::OFS_PERIPH_CTRL, 8'h00);
      repeat (2) @(negedge clk);
      chk("pins_rel", 8'h03, {6'h00, ckp.oe_n, dtp.oe_n});
      $display("t_off done");
   endtask
   task automatic t_int(input logic [2:0] m, input logic [7:0] n,
                        input logic [7:0] d);
      int h;
      h = m[1] ? int'(ssi_pkg::SYS_HALF) :
         int'(n) + int'(ssi_pkg::T2_OVERHEAD);
      acc(1'b0, ssi_pkg::OFS_T2_LATCH_LO, n);
      set_mode(m);
      tx = d;
      frame(4'h0);
      acc(~m[2], A_SH, d);
      wait_irq;
      repeat (30) @(negedge clk);
      chk("pulses", 8'h08, 8'(np));
      chk("spacing", 8'(14 * h), 8'((tl - tf) / 20));
      if (m[2]) begin
         chk("sent", d, rx);
         chk("last", {7'h00, d[0]}, {7'h00, dat_line});
      end
      set_mode(ssi_pkg::MODE_OFF);
      rchk("flag_off", A_IFR, 8'h00);
      if (m == ssi_pkg::MODE_IN_T2) rchk("got", A_SH, d);
      $display("t_int mode %0d done", m);
   endtask
   task automatic t_ext(input logic [2:0] m);
      set_mode(m);
      acc(1'b0, A_SH, 8'h5A);
      tx = 8'h96;
      frame(4'h7);
      repeat (40) @(negedge clk);
      chk("no_flag7", 8'h01, {7'h00, irq.oe_n});
      frame(4'h1);
      wait_irq;
      rchk("ext_sh", A_SH, m[2] ? 8'h5A : {tx[7:1], tx[7]});
      repeat (3) @(negedge clk);
      chk("flag_clr", 8'h01, {7'h00, irq.oe_n});
      set_mode(ssi_pkg::MODE_OFF);
      $display("t_ext mode %0d done", m);
   endtask
   task automatic t_free;
      logic [15:0] w;
      logic ok;
      w = 16'h8181;
      ok = 1'b0;
      acc(1'b0, ssi_pkg::OFS_T2_LATCH_LO, 8'h00);
      set_mode(ssi_pkg::MODE_OUT_FREE);
      frame(4'h0);
      acc(1'b0, A_SH, 8'h81);
      repeat (200) @(negedge clk);
      chk("free_runs", 8'h01, {7'h00, np > 8});
      rchk("free_flag", A_IFR, 8'h00);
      for (int i = 0; i < 8; i++) if (rx === w[i +: 8]) ok = 1'b1;
      chk("recirc", 8'h01, {7'h00, ok});
      set_mode(ssi_pkg::MODE_OFF);
      $display("t_free done");
   endtask

   // ==========
   // Main sequence and watchdog.
   initial begin
      @(negedge clk);
      frame(4'h3);
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_regs;
      t_off;
      t_int(ssi_pkg::MODE_OUT_T2, 8'h03, 8'hA5);
      t_int(ssi_pkg::MODE_OUT_SYS, 8'h03, 8'h3C);
      t_int(ssi_pkg::MODE_IN_T2, 8'h06, 8'h3C);
      t_int(ssi_pkg::MODE_IN_SYS, 8'h00, 8'hC3);
      t_ext(ssi_pkg::MODE_IN_EXT);
      t_ext(ssi_pkg::MODE_OUT_EXT);
      t_free;
      end_of_test;
   end
   initial begin
      #200000;
      fails++;
      end_of_test;
   end
endmodule

`default_nettype wire
